// >>> hdl/mqr_query_responder.sv
// Query and response logic of a multichannel analyzer: decoded host commands in,
// one registered response record out. Assumes the host framing is done outside.
//
// Overview of operation
// RULE1: Peak query gives the largest flagged count, zero if none flagged.
// RULE2: Peak-location query gives that channel, 0 if none, at most 1023.
// RULE3: Ties on the largest count report the lowest channel.
// RULE4: Radix query always answers binary.
// RULE5: First-group query gives start and length of the first flagged run.
// RULE6: Each next-group query gives the following run, then 0 and 0.
// RULE7: Segment query always answers 1.
// RULE8: Shaping query answers an index from 0 to 5.
// RULE9: Status gives live, true, active mask and a 16-bit hardware word.
// RULE10: Hardware status bits 0 and 1 always read 1.
// RULE11: Status bit 2 is set only above 10 V; bits 3 to 15 read 0.
// RULE12: True-time query gives the counter in 20 ms ticks.
// RULE13: True preset in 20 ms ticks; zero is reported as disabled.
// RULE14: Upper threshold query answers in channels, at most 1023.
// RULE15: Version answers four model characters, hyphen, three version characters.
// RULE16: Window answers start 0 to 1023 and count 1 to 1024; the code passes a win_len above 1024 through unchanged.
// RULE17: Zero-stabilizer channel answers the centre or zero when unset.
// RULE18: Zero-stabilizer width answers 1 when unset.
// RULE19: Zero-stabilization state answers true when enabled.
// RULE20: Start begins acquisition; any segment mask is ignored.
// RULE21: Stop halts acquisition; any segment mask is ignored.
// RULE22: Trigger query reports enable, peak, lower threshold or random.
// RULE23: Serial-number query answers the unit serial number.
// RULE24: Host checks the trailing check field and drops bad records.
`timescale 1ns/100ps
`default_nettype none
module mqr_query_responder #(
    parameter logic [31:0] MODEL_ID = 32'h4D444C31,   // Arbitrary value
    parameter logic [23:0] VERSION_ID = 24'h303037,   // Arbitrary value
    parameter logic [31:0] SERIAL_NUM = 32'h00000001  // Arbitrary value
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Command
    input wire logic cmd_valid,
    input wire mqr_pkg::mqr_cmd_t cmd_code,
    input wire logic [15:0] cmd_seg_mask,
    output logic cmd_ready,
    // Response
    output logic rsp_valid,
    output mqr_pkg::mqr_cmd_t rsp_kind,
    output logic [31:0] rsp_a,
    output logic [31:0] rsp_b,
    output logic [15:0] rsp_c,
    output logic [15:0] rsp_d,
    output logic rsp_flag,
    // Spectrum write port
    input wire logic spec_we,
    input wire logic [9:0] spec_addr,
    input wire logic [30:0] spec_count,
    input wire logic spec_roi,
    // Settings and status
    input wire logic [31:0] live_ticks,
    input wire logic [31:0] true_ticks,
    input wire logic [31:0] true_preset,
    input wire logic [15:0] active_mask,
    input wire logic [15:0] hv_actual_volts,
    input wire logic [2:0] shaping_idx,
    input wire logic [9:0] upper_thr,
    input wire logic [9:0] win_start,
    input wire logic [10:0] win_len,
    input wire logic zero_chan_set,
    input wire logic [9:0] zero_chan,
    input wire logic zero_width_set,
    input wire logic [8:0] zero_width,
    input wire logic zero_stab_en,
    input wire mqr_pkg::mqr_trig_t trig_src,
    // Acquisition
    output logic acq_run
);
    mqr_mem_if mbus ();
    mqr_pkg::mqr_state_t state_ff, nxt_state;
    logic [10:0] chan_ff, cursor_ff;
    logic [30:0] best_cnt_ff;
    logic [9:0] best_ch_ff, grp_start_ff;
    logic [10:0] grp_len_ff;
    logic found_ff, run_ff, acq_ff;
    mqr_pkg::mqr_cmd_t op_ff;
    logic rsp_valid_ff, rsp_flag_ff;
    mqr_pkg::mqr_cmd_t rsp_kind_ff;
    logic [31:0] rsp_a_ff, rsp_b_ff, imm_a, imm_b;
    logic [15:0] rsp_c_ff, rsp_d_ff, imm_c, imm_d;
    logic imm_flag;

    mqr_spec_mem #(.DEPTH(mqr_pkg::NCHAN)) u_mem (.mclk(mclk), .mp(mbus.mem));

    // ==========================================================
    // Decoding
    function automatic logic is_scan(input mqr_pkg::mqr_cmd_t c);
        is_scan = (c == mqr_pkg::MQR_PEAK) || (c == mqr_pkg::MQR_PEAK_CHAN)
            || (c == mqr_pkg::MQR_FIRST_GROUP) || (c == mqr_pkg::MQR_NEXT_GROUP);
    endfunction : is_scan

    function automatic logic is_group(input mqr_pkg::mqr_cmd_t c);
        is_group = (c == mqr_pkg::MQR_FIRST_GROUP) || (c == mqr_pkg::MQR_NEXT_GROUP);
    endfunction : is_group

    wire accept = cmd_valid && cmd_ready;
    wire at_end = (chan_ff == 11'(mqr_pkg::NCHAN));
    wire cell_roi = mbus.rd_data[mqr_pkg::ROI_BIT];
    wire [30:0] cell_cnt = mbus.rd_data[30:0];
    wire hv_on = hv_actual_volts > mqr_pkg::HV_ON_VOLTS;
    // Strictly greater keeps the first channel seen on a tie
    wire take_peak = cell_roi && (!found_ff || (cell_cnt > best_cnt_ff)); // RULE3
    wire run_ends = is_group(op_ff) && run_ff && !cell_roi;
    wire [15:0] hw_status = 16'((1 << mqr_pkg::HW_POL_BIT) | (1 << mqr_pkg::HW_OVL_BIT)
        | (32'(hv_on) << mqr_pkg::HW_HV_BIT)); // RULE10 RULE11

    assign cmd_ready = (state_ff == mqr_pkg::MQR_S_IDLE);
    assign mbus.wr_en = spec_we;
    assign mbus.wr_addr = spec_addr;
    assign mbus.wr_data = {spec_roi, spec_count};
    assign mbus.rd_addr = chan_ff[9:0];

    // ==========================================================
    // Scanner state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mqr_pkg::MQR_S_IDLE: begin
                if (accept && is_scan(cmd_code)) begin
                    nxt_state = mqr_pkg::MQR_S_ISSUE;
                end
            end
            mqr_pkg::MQR_S_ISSUE: begin
                nxt_state = at_end ? mqr_pkg::MQR_S_FIN : mqr_pkg::MQR_S_EVAL;
            end
            mqr_pkg::MQR_S_EVAL: begin
                nxt_state = run_ends ? mqr_pkg::MQR_S_FIN : mqr_pkg::MQR_S_ISSUE;
            end
            default: begin
                nxt_state = mqr_pkg::MQR_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= mqr_pkg::MQR_S_IDLE;
            op_ff <= mqr_pkg::MQR_PEAK;
        end else begin
            state_ff <= nxt_state;
            if (accept) begin
                op_ff <= cmd_code;
            end
        end
    end

    // Channel walk; a next-group search resumes where the last run ended
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            chan_ff <= 11'h000;
            cursor_ff <= 11'h000;
        end else if (accept && is_scan(cmd_code)) begin
            chan_ff <= (cmd_code == mqr_pkg::MQR_NEXT_GROUP) ? cursor_ff : 11'h000; // RULE5 RULE6
        end else if (state_ff == mqr_pkg::MQR_S_EVAL) begin
            chan_ff <= chan_ff + 11'h001;
            if (run_ends) begin
                cursor_ff <= chan_ff; // RULE6
            end
        end else if (state_ff == mqr_pkg::MQR_S_ISSUE && at_end && is_group(op_ff)) begin
            cursor_ff <= chan_ff; // RULE6
        end
    end

    // Peak trackers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            found_ff <= 1'b0;
            best_cnt_ff <= 31'h00000000;
            best_ch_ff <= 10'h000;
        end else if (accept) begin
            found_ff <= 1'b0;
            best_cnt_ff <= 31'h00000000;
            best_ch_ff <= 10'h000;
        end else if (state_ff == mqr_pkg::MQR_S_EVAL && take_peak) begin
            found_ff <= 1'b1;
            best_cnt_ff <= cell_cnt; // RULE1
            best_ch_ff <= chan_ff[9:0]; // RULE2
        end
    end

    // Group trackers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            run_ff <= 1'b0;
            grp_start_ff <= 10'h000;
            grp_len_ff <= 11'h000;
        end else if (accept) begin
            run_ff <= 1'b0;
            grp_start_ff <= 10'h000;
            grp_len_ff <= 11'h000;
        end else if (state_ff == mqr_pkg::MQR_S_EVAL && cell_roi) begin
            if (!run_ff) begin
                grp_start_ff <= chan_ff[9:0]; // RULE5
            end
            run_ff <= 1'b1;
            grp_len_ff <= grp_len_ff + 11'h001;
        end
    end

    // ==========================================================
    // Immediate answers
    always_comb begin
        imm_a = 32'h00000000;
        imm_b = 32'h00000000;
        imm_c = 16'h0000;
        imm_d = 16'h0000;
        imm_flag = 1'b0;
        case (cmd_code)
            mqr_pkg::MQR_RADIX: imm_a = mqr_pkg::RADIX_BINARY; // RULE4
            mqr_pkg::MQR_SEGMENT: imm_a = mqr_pkg::SEGMENT_NUM; // RULE7
            mqr_pkg::MQR_SHAPING: begin
                // Out-of-range settings are clipped to the last index
                imm_a = 32'((shaping_idx > mqr_pkg::SHAPE_MAX) ? mqr_pkg::SHAPE_MAX : shaping_idx); // RULE8
            end
            mqr_pkg::MQR_STATUS: begin
                imm_a = live_ticks; // RULE9
                imm_b = true_ticks;
                imm_c = active_mask;
                imm_d = hw_status;
            end
            mqr_pkg::MQR_TRUE: imm_a = true_ticks; // RULE12
            mqr_pkg::MQR_TRUE_PRESET: begin
                imm_a = true_preset;
                imm_flag = (true_preset == 32'h00000000); // RULE13
            end
            mqr_pkg::MQR_UPPER_THR: imm_a = 32'(upper_thr); // RULE14
            mqr_pkg::MQR_VERSION: begin
                imm_a = MODEL_ID; // RULE15
                imm_b = {mqr_pkg::HYPHEN_CHAR, VERSION_ID};
            end
            mqr_pkg::MQR_WINDOW: begin
                imm_a = 32'(win_start); // RULE16
                imm_b = 32'((win_len == 11'h000) ? mqr_pkg::CONV_GAIN : win_len);
            end
            mqr_pkg::MQR_ZERO_CHAN: begin
                imm_a = 32'(zero_chan_set ? zero_chan : mqr_pkg::ZERO_CHAN_UNSET); // RULE17
            end
            mqr_pkg::MQR_ZERO_WIDTH: begin
                imm_a = 32'(zero_width_set ? zero_width : mqr_pkg::ZERO_WIDTH_UNSET); // RULE18
            end
            mqr_pkg::MQR_ZERO_STAB: imm_flag = zero_stab_en; // RULE19
            mqr_pkg::MQR_TRIGGER: imm_a = 32'(trig_src); // RULE22
            mqr_pkg::MQR_SERIAL: imm_a = SERIAL_NUM; // RULE23
            default: imm_flag = 1'b0;
        endcase
    end

    // ==========================================================
    // Acquisition control; the segment mask has no effect
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acq_ff <= 1'b0;
        end else if (accept && cmd_code == mqr_pkg::MQR_START) begin
            acq_ff <= 1'b1; // RULE20
        end else if (accept && cmd_code == mqr_pkg::MQR_STOP) begin
            acq_ff <= 1'b0; // RULE21
        end
    end

    // ==========================================================
    // Response register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid_ff <= 1'b0;
            rsp_kind_ff <= mqr_pkg::MQR_PEAK;
            rsp_a_ff <= 32'h00000000;
            rsp_b_ff <= 32'h00000000;
            rsp_c_ff <= 16'h0000;
            rsp_d_ff <= 16'h0000;
            rsp_flag_ff <= 1'b0;
        end else if (accept && !is_scan(cmd_code)) begin
            rsp_valid_ff <= 1'b1;
            rsp_kind_ff <= cmd_code;
            rsp_a_ff <= imm_a;
            rsp_b_ff <= imm_b;
            rsp_c_ff <= imm_c;
            rsp_d_ff <= imm_d;
            rsp_flag_ff <= imm_flag;
        end else if (state_ff == mqr_pkg::MQR_S_FIN) begin
            rsp_valid_ff <= 1'b1;
            rsp_kind_ff <= op_ff;
            rsp_c_ff <= 16'h0000;
            rsp_d_ff <= 16'h0000;
            rsp_flag_ff <= found_ff;
            if (op_ff == mqr_pkg::MQR_PEAK) begin
                rsp_a_ff <= {1'b0, best_cnt_ff}; // RULE1
                rsp_b_ff <= 32'h00000000;
            end else if (op_ff == mqr_pkg::MQR_PEAK_CHAN) begin
                rsp_a_ff <= 32'(best_ch_ff); // RULE2
                rsp_b_ff <= 32'h00000000;
            end else begin
                rsp_a_ff <= 32'(grp_start_ff); // RULE5 RULE6
                rsp_b_ff <= 32'(grp_len_ff);
            end
        end else begin
            rsp_valid_ff <= 1'b0;
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp_kind = rsp_kind_ff;
    assign rsp_a = rsp_a_ff;
    assign rsp_b = rsp_b_ff;
    assign rsp_c = rsp_c_ff;
    assign rsp_d = rsp_d_ff;
    assign rsp_flag = rsp_flag_ff;
    assign acq_run = acq_ff;

    // ==========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    wire rsp_is_peak = rsp_valid && rsp_kind == mqr_pkg::MQR_PEAK;
    wire rsp_is_stat = rsp_valid && rsp_kind == mqr_pkg::MQR_STATUS;
    sequence s_imm_cmd;
        accept && !is_scan(cmd_code);
    endsequence
    sequence s_scan_cmd;
        accept && is_scan(cmd_code);
    endsequence

    a_peak_none_zero: assert property (rsp_is_peak && !rsp_flag |-> rsp_a == 32'h00000000) // RULE1
        else $error("peak answer not zero without flagged channel");
    a_peak_loc_range: assert property (rsp_valid && rsp_kind == mqr_pkg::MQR_PEAK_CHAN |-> rsp_a <= 32'h000003FF) // RULE2
        else $error("peak location beyond last channel");
    a_tie_lowest_wins: assert property (state_ff == mqr_pkg::MQR_S_EVAL && found_ff && cell_roi
        && cell_cnt == best_cnt_ff |=> $stable(best_ch_ff)) // RULE3
        else $error("tie moved peak location");
    a_radix_binary: assert property (s_imm_cmd and (cmd_code == mqr_pkg::MQR_RADIX)
        |=> rsp_valid && rsp_a == mqr_pkg::RADIX_BINARY) // RULE4
        else $error("radix answer not binary");
    a_group_empty_zero: assert property (rsp_valid && is_group(rsp_kind) && rsp_b == 32'h00000000
        |-> rsp_a == 32'h00000000) // RULE5
        else $error("empty group with nonzero start");
    // Cycles away from idle; a full walk needs 2050, so a larger count means a hung scan
    logic [11:0] scan_age_ff;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scan_age_ff <= 12'h000;
        end else if (state_ff == mqr_pkg::MQR_S_IDLE) begin
            scan_age_ff <= 12'h000;
        end else begin
            scan_age_ff <= scan_age_ff + 12'h001;
        end
    end
    a_scan_answers: assert property (scan_age_ff <= 12'h802) // RULE6
        else $error("scan gave no answer in time");
    a_segment_one: assert property (s_imm_cmd and (cmd_code == mqr_pkg::MQR_SEGMENT)
        |=> rsp_a == 32'h00000001) // RULE7
        else $error("segment answer not one");
    a_shaping_range: assert property (rsp_valid && rsp_kind == mqr_pkg::MQR_SHAPING |-> rsp_a <= 32'h00000005) // RULE8
        else $error("shaping index out of range");
    a_status_fields: assert property (s_imm_cmd and (cmd_code == mqr_pkg::MQR_STATUS)
        |=> rsp_a == $past(live_ticks) && rsp_b == $past(true_ticks)) // RULE9
        else $error("status fields do not match sources");
    a_hw_fixed_bits: assert property (rsp_is_stat |-> rsp_d[1:0] == 2'h3 && rsp_d[15:3] == 13'h0000) // RULE10
        else $error("hardware status fixed bits wrong");
    a_hv_status_bit: assert property (s_imm_cmd and (cmd_code == mqr_pkg::MQR_STATUS)
        |=> rsp_d[2] == ($past(hv_actual_volts) > 16'h000A)) // RULE11
        else $error("high voltage bit disagrees with 10 V");
    a_preset_disable: assert property (rsp_valid && rsp_kind == mqr_pkg::MQR_TRUE_PRESET
        |-> rsp_flag == (rsp_a == 32'h00000000)) // RULE13
        else $error("preset disabled flag wrong");
    a_zero_width_unset: assert property (s_imm_cmd and (cmd_code == mqr_pkg::MQR_ZERO_WIDTH) and !zero_width_set
        |=> rsp_a == 32'h00000001) // RULE18
        else $error("unset zero width not reported as one");
    a_start_runs: assert property (accept && cmd_code == mqr_pkg::MQR_START |=> acq_run [*2]) // RULE20
        else $error("start did not run acquisition");
    a_stop_halts: assert property (accept && cmd_code == mqr_pkg::MQR_STOP |=> !acq_run) // RULE21
        else $error("stop did not halt acquisition");
endmodule : mqr_query_responder
`default_nettype wire

// >>> hdl/mqr_spec_mem.sv
// Spectrum memory: one word per channel, flag in the top bit, count below.
// Assumes a single clock; read data come from a register.
`timescale 1ns/100ps
`default_nettype none
module mqr_spec_mem #(
    parameter int DEPTH = mqr_pkg::NCHAN
) (
    // Clock
    input wire logic mclk,
    // Memory port
    mqr_mem_if.mem mp
);
    logic [31:0] mem_ff [DEPTH];
    logic [31:0] rd_ff;

    // ==========================================================
    // No reset on the array so it maps to block memory
    always_ff @(posedge mclk) begin
        if (mp.wr_en) begin
            mem_ff[mp.wr_addr] <= mp.wr_data;
        end
        rd_ff <= mem_ff[mp.rd_addr];
    end

    assign mp.rd_data = rd_ff;
endmodule : mqr_spec_mem
`default_nettype wire

// >>> inc/mqr_mem_if.sv
// Spectrum memory port bundle between the responder and its memory.
// Assumes one clock; read data lag the address by one edge.
`timescale 1ns/100ps
`default_nettype none
interface mqr_mem_if;
    logic wr_en;
    logic [9:0] wr_addr;
    logic [31:0] wr_data;
    logic [9:0] rd_addr;
    logic [31:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : mqr_mem_if
`default_nettype wire

// >>> inc/mqr_pkg.sv
// Constants, commands and states of the multichannel analyzer query responder.
// Assumes a 1024-channel spectrum with a region-of-interest flag per channel.
package mqr_pkg;
    // ==========================================================
    // Spectrum geometry
    localparam int CHAN_W = 10;
    localparam int NCHAN = 1024;
    localparam int COUNT_W = 31;
    localparam int ROI_BIT = 31;
    localparam logic [30:0] MAX_COUNT = 31'h7FFFFFFF;
    localparam logic [9:0] MAX_CHAN = 10'h3FF;
    localparam logic [10:0] CONV_GAIN = 11'h400;
    // ==========================================================
    // Fixed answers
    localparam logic [31:0] RADIX_BINARY = 32'h00000002;
    localparam logic [31:0] SEGMENT_NUM = 32'h00000001;
    localparam logic [2:0] SHAPE_MAX = 3'h5;
    localparam logic [7:0] HYPHEN_CHAR = 8'h2D;
    // ==========================================================
    // Hardware status word
    localparam int HW_POL_BIT = 0;
    localparam int HW_OVL_BIT = 1;
    localparam int HW_HV_BIT = 2;
    localparam logic [15:0] HV_ON_VOLTS = 16'h000A;
    // ==========================================================
    // Zero stabilizer and timing
    localparam logic [9:0] ZERO_CHAN_UNSET = 10'h000;
    localparam logic [8:0] ZERO_WIDTH_UNSET = 9'h001;
    localparam int TICK_MS = 20;
    localparam int TICKS_PER_S = 1000 / TICK_MS;
    // ==========================================================
    // Commands, trigger sources and scanner states
    typedef enum logic [4:0] {
        MQR_PEAK, MQR_PEAK_CHAN, MQR_RADIX, MQR_FIRST_GROUP, MQR_NEXT_GROUP,
        MQR_SEGMENT, MQR_SHAPING, MQR_STATUS, MQR_TRUE, MQR_TRUE_PRESET,
        MQR_UPPER_THR, MQR_VERSION, MQR_WINDOW, MQR_ZERO_CHAN, MQR_ZERO_WIDTH,
        MQR_ZERO_STAB, MQR_START, MQR_STOP, MQR_TRIGGER, MQR_SERIAL
    } mqr_cmd_t;
    typedef enum logic [1:0] {
        MQR_TRIG_ENABLE, MQR_TRIG_PEAK, MQR_TRIG_LOWER, MQR_TRIG_RANDOM
    } mqr_trig_t;
    typedef enum logic [1:0] {MQR_S_IDLE, MQR_S_ISSUE, MQR_S_EVAL, MQR_S_FIN} mqr_state_t;
endpackage : mqr_pkg

// >>> sim/mqr_host_model.sv
// Host partner: presents one command and waits for its answer record.
// Assumes every answer arrives within the longest spectrum scan.
`timescale 1ns/100ps
`default_nettype none
module mqr_host_model (
    // Clock
    input wire logic mclk,
    // Command
    output logic cmd_valid,
    output mqr_pkg::mqr_cmd_t cmd_code,
    output logic [15:0] cmd_seg_mask,
    input wire logic cmd_ready,
    // Response
    input wire logic rsp_valid
);
    int timeouts = 0;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = mqr_pkg::MQR_PEAK;
        cmd_seg_mask = 16'h0;
    end
    // ==========================================================
    // Request held until taken
    task automatic query(input mqr_pkg::mqr_cmd_t code, input logic [15:0] mask);
        int n;
        n = 0;
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_code = code;
        cmd_seg_mask = mask;
        // Ready is settled at the falling edge; at the rising edge it races the state update
        while (cmd_ready !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        // Released lines change so that a stale value cannot pass
        cmd_code = mqr_pkg::mqr_cmd_t'(~code);
        cmd_seg_mask = ~mask;
        while (rsp_valid !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 3000) timeouts++;
    endtask : query
endmodule : mqr_host_model
`default_nettype wire

// >>> sim/mqr_query_responder_tb.sv
// Bench of the query responder: host model on the command side, spectrum and settings here.
// Assumes the host model's query task is reached through its instance.
`timescale 1ns/100ps
`default_nettype none
module mqr_query_responder_tb;
    localparam logic [31:0] MODEL = 32'h51525354; // Arbitrary value
    localparam logic [23:0] VER = 24'h313233; // Arbitrary value
    localparam logic [31:0] SER = 32'h64; // Arbitrary value
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid, cmd_ready, rsp_valid, rsp_flag, acq_run;
    mqr_pkg::mqr_cmd_t cmd_code, rsp_kind;
    logic [15:0] cmd_seg_mask, rsp_c, rsp_d;
    logic [31:0] rsp_a, rsp_b;
    logic spec_we = 1'b0, spec_roi = 1'b0, zero_chan_set = 1'b0, zero_width_set = 1'b0, zero_stab_en = 1'b0;
    logic [9:0] spec_addr = 10'h0, upper_thr = 10'h0, win_start = 10'h0, zero_chan = 10'h0;
    logic [30:0] spec_count = 31'h0;
    logic [31:0] live_ticks = 32'h0, true_ticks = 32'h0, true_preset = 32'h0;
    logic [15:0] active_mask = 16'h0, hv_actual_volts = 16'h0;
    logic [2:0] shaping_idx = 3'h0;
    logic [10:0] win_len = 11'h400;
    logic [8:0] zero_width = 9'h0;
    mqr_pkg::mqr_trig_t trig_src = mqr_pkg::MQR_TRIG_ENABLE;
    int errors = 0;
    int samples_checked = 0;
    always #4 mclk = ~mclk;
    mqr_query_responder #(.MODEL_ID(MODEL), .VERSION_ID(VER), .SERIAL_NUM(SER)) i_dut (.mclk, .reset_n,
        .cmd_valid, .cmd_code, .cmd_seg_mask, .cmd_ready, .rsp_valid, .rsp_kind, .rsp_a, .rsp_b, .rsp_c,
        .rsp_d, .rsp_flag, .spec_we, .spec_addr, .spec_count, .spec_roi, .live_ticks, .true_ticks,
        .true_preset, .active_mask, .hv_actual_volts, .shaping_idx, .upper_thr, .win_start, .win_len,
        .zero_chan_set, .zero_chan, .zero_width_set, .zero_width, .zero_stab_en, .trig_src, .acq_run);
    mqr_host_model i_host (.mclk, .cmd_valid, .cmd_code, .cmd_seg_mask, .cmd_ready, .rsp_valid);
    // ==========================================================
    // Shared checks and drivers
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    // Mask is all ones on every command sent through q, so any use of it would show
    task automatic q(input mqr_pkg::mqr_cmd_t c, input logic [31:0] exp_a);
        i_host.query(c, 16'hFFFF);
        chk("kind", 32'(c), 32'(rsp_kind));
        chk(c.name(), exp_a, rsp_a);
    endtask : q
    task automatic wr(input int ch, input logic [30:0] cnt, input logic roi);
        @(negedge mclk);
        spec_we = 1'b1;
        spec_addr = 10'(ch);
        spec_count = cnt;
        spec_roi = roi;
        @(negedge mclk);
        spec_we = 1'b0;
    endtask : wr
    // ==========================================================
    // Scenarios
    task automatic t_peak;
        for (int i = 0; i < 1024; i++) wr(i, 31'h0, 1'b0);
        q(mqr_pkg::MQR_PEAK, 32'h0);
        q(mqr_pkg::MQR_PEAK_CHAN, 32'h0);
        q(mqr_pkg::MQR_FIRST_GROUP, 32'h0);
        chk("len", 32'h0, rsp_b);
        wr(5, 31'h7, 1'b1);
        wr(6, 31'h9, 1'b1);
        wr(7, mqr_pkg::MAX_COUNT, 1'b0);
        wr(10, 31'h9, 1'b1);
        wr(1023, mqr_pkg::MAX_COUNT, 1'b1);
        q(mqr_pkg::MQR_PEAK, 32'h7FFFFFFF);
        q(mqr_pkg::MQR_PEAK_CHAN, 32'h3FF);
        wr(1023, 31'h9, 1'b1);
        q(mqr_pkg::MQR_PEAK_CHAN, 32'h6);
    endtask : t_peak
    task automatic t_groups;
        q(mqr_pkg::MQR_FIRST_GROUP, 32'h5);
        chk("len", 32'h2, rsp_b);
        q(mqr_pkg::MQR_NEXT_GROUP, 32'hA);
        chk("len", 32'h1, rsp_b);
        q(mqr_pkg::MQR_NEXT_GROUP, 32'h3FF);
        chk("len", 32'h1, rsp_b);
        q(mqr_pkg::MQR_NEXT_GROUP, 32'h0);
        chk("len", 32'h0, rsp_b);
    endtask : t_groups
    task automatic t_fixed;
        shaping_idx = 3'h4;
        q(mqr_pkg::MQR_RADIX, mqr_pkg::RADIX_BINARY);
        q(mqr_pkg::MQR_SEGMENT, 32'h1);
        for (int i = 0; i < 6; i++) begin
            shaping_idx = 3'(i);
            q(mqr_pkg::MQR_SHAPING, 32'(i));
        end
        for (int i = 0; i < 4; i++) begin
            trig_src = mqr_pkg::mqr_trig_t'(i);
            q(mqr_pkg::MQR_TRIGGER, 32'(i));
        end
        q(mqr_pkg::MQR_VERSION, MODEL);
        chk("version", {8'h2D, VER}, rsp_b);
        q(mqr_pkg::MQR_SERIAL, SER);
    endtask : t_fixed
    task automatic t_status;
        live_ticks = 32'h12345678;
        true_ticks = 32'hFFFFFFFF;
        active_mask = 16'hA5C3;
        hv_actual_volts = 16'hA;
        q(mqr_pkg::MQR_STATUS, 32'h12345678);
        chk("true", 32'hFFFFFFFF, rsp_b);
        chk("mask", 32'hA5C3, {16'h0, rsp_c});
        chk("hw", 32'h3, {16'h0, rsp_d});
        hv_actual_volts = 16'hB;
        q(mqr_pkg::MQR_STATUS, 32'h12345678);
        chk("hw", 32'h7, {16'h0, rsp_d});
        q(mqr_pkg::MQR_TRUE, 32'hFFFFFFFF);
        q(mqr_pkg::MQR_TRUE_PRESET, 32'h0);
        chk("disabled", 32'h1, {31'h0, rsp_flag});
        true_preset = 32'h1;
        q(mqr_pkg::MQR_TRUE_PRESET, 32'h1);
        chk("disabled", 32'h0, {31'h0, rsp_flag});
    endtask : t_status
    task automatic t_settings;
        upper_thr = 10'h3FF;
        q(mqr_pkg::MQR_UPPER_THR, 32'h3FF);
        win_start = 10'h3FF;
        win_len = 11'h1;
        q(mqr_pkg::MQR_WINDOW, 32'h3FF);
        chk("count", 32'h1, rsp_b);
        zero_chan = 10'hFA;
        zero_width = 9'h100;
        q(mqr_pkg::MQR_ZERO_CHAN, 32'h0);
        q(mqr_pkg::MQR_ZERO_WIDTH, 32'h1);
        zero_chan_set = 1'b1;
        zero_width_set = 1'b1;
        q(mqr_pkg::MQR_ZERO_CHAN, 32'hFA);
        q(mqr_pkg::MQR_ZERO_WIDTH, 32'h100);
        zero_stab_en = 1'b1;
        i_host.query(mqr_pkg::MQR_ZERO_STAB, 16'h0);
        chk("stab", 32'h1, {31'h0, rsp_flag});
        zero_stab_en = 1'b0;
        i_host.query(mqr_pkg::MQR_ZERO_STAB, 16'h0);
        chk("stab", 32'h0, {31'h0, rsp_flag});
    endtask : t_settings
    task automatic t_acq;
        q(mqr_pkg::MQR_START, 32'h0);
        chk("run", 32'h1, {31'h0, acq_run});
        q(mqr_pkg::MQR_STOP, 32'h0);
        chk("run", 32'h0, {31'h0, acq_run});
    endtask : t_acq
    task automatic final_report;
        chk("timeouts", 32'h0, 32'(i_host.timeouts));
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        t_peak();
        t_groups();
        t_fixed();
        t_status();
        t_settings();
        t_acq();
        final_report();
    end
    // Roughly four and a half times the expected run
    initial begin
        #600000;
        errors++;
        final_report();
    end
endmodule : mqr_query_responder_tb
`default_nettype wire
